// *** logic/awac_cfg_if.sv ***
`timescale 1ns/1ps
interface awac_cfg_if;
  logic [31:0] settle_cfg;
  logic [31:0] analog_cfg;
  logic        warm_req;
  logic        warm_done;
  modport regs  (output settle_cfg, output analog_cfg, output warm_req, input warm_done);
  modport timer (input settle_cfg, input warm_req, output warm_done);
endinterface // awac_cfg_if

// *** logic/awac_pkg.sv ***
package awac_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  SETTLE_CFG_OFS  = 8'h0c;
  localparam logic [7:0]  ANALOG_CFG_OFS  = 8'h10;
  localparam logic [7:0]  STATUS_OFS      = 8'h14;
  // ==========================================================
  // settle register fields
  localparam int          SETTLE_DUR_LSB  = 0;
  localparam int          SETTLE_DUR_W    = 5;
  localparam int          SKIP_SETTLE_BIT = 5;
  localparam logic [4:0]  SETTLE_DUR_RST  = 5'h0f;
  localparam logic [31:0] SETTLE_WMASK    = 32'h0000003f;
  // ==========================================================
  // analog register fields
  localparam logic [31:0] ANALOG_WMASK    = 32'h0007fc3f;
  localparam logic [31:0] ANALOG_RST      = 32'h0000a810;
  localparam int          RES_LSB         = 17;
  localparam int          BIAS_BIT        = 16;
  localparam int          CHOP_BIT        = 15;
  localparam int          INBUF_EN_BIT    = 14;
  localparam int          INBUF_CHOP_BIT  = 13;
  localparam int          GAIN_LSB        = 11;
  localparam int          DIFF_BIT        = 10;
  localparam int          VREF_LSB        = 4;
  localparam int          VREF_CHOP_BIT   = 3;
  localparam int          SCF_BYP_BIT     = 2;
  localparam int          PROBE_ON_BIT    = 1;
  localparam int          DIODE_EXT_BIT   = 0;
  localparam logic [1:0]  RES_12BIT       = 2'h0;
  localparam logic [1:0]  GAIN_RESERVED   = 2'h3;
  // ==========================================================
  // timing
  localparam int          CLK_MHZ         = 100;
  localparam int          TICK_US         = 1;
  localparam int          TICK_CYCLES     = (TICK_US * CLK_MHZ < 1) ? 1 : TICK_US * CLK_MHZ;
  // ==========================================================
  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {AWAC_IDLE, AWAC_SETTLE, AWAC_READY} awac_state_e;

  function automatic logic [31:0] awac_merge(input logic [31:0] old_v, input logic [31:0] wd,
                                             input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r & msk;
  endfunction
endpackage

// *** logic/awac_settle_timer.sv ***
`timescale 1ns/1ps
module awac_settle_timer
  import awac_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // configuration
  awac_cfg_if.timer cfg
);
  // the divider is 16 bits wide, so longer ticks cannot be counted
  if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_bad_tick
    $error("tick must be 1 to 65536 cycles");
  end
  // ==========================================================
  // one-microsecond tick divider
  logic [15:0] div_ff;
  logic        tick;
  assign tick = (div_ff == 16'(TICK_CYC - 1));
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_ff <= 16'h0000;
    end else if (tick || !cfg.warm_req) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  // ==========================================================
  // warm-up state machine
  awac_state_e state_ff;
  logic [5:0]  us_ff;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_ff <= AWAC_IDLE;
      us_ff    <= 6'h00;
    end else begin
      unique case (state_ff)
        AWAC_IDLE: begin
          us_ff <= 6'h00;
          if (cfg.warm_req) begin
            if (cfg.settle_cfg[SKIP_SETTLE_BIT]) begin
              state_ff <= AWAC_READY;
            end else begin
              state_ff <= AWAC_SETTLE;
            end
          end
        end
        AWAC_SETTLE: begin
          if (!cfg.warm_req) begin
            state_ff <= AWAC_IDLE;
          end else if (tick) begin
            // duration field plus one microseconds
            if (us_ff == {1'b0, cfg.settle_cfg[SETTLE_DUR_LSB +: SETTLE_DUR_W]}) begin
              state_ff <= AWAC_READY;
            end
            us_ff <= us_ff + 6'h01;
          end
        end
        AWAC_READY: begin
          if (!cfg.warm_req) begin
            state_ff <= AWAC_IDLE;
          end
        end
      endcase
    end
  end
  assign cfg.warm_done = (state_ff == AWAC_READY);
endmodule // awac_settle_timer

// *** logic/awac_top.sv ***
// How it works
// - skip bit set: no warm-up state, ready at once.
// - skip bit clear: warm-up state timed by the duration field.
// - warm-up lasts duration plus one microseconds; field resets to 0xf.
// - bits 18:17 pick resolution and data rate mode.
// - bit 16 halves modulator bias current.
// - bit 15 chopper, reset 1, applied only in 12-bit mode.
// - bit 14 enables the input gain buffer, reset 0.
// - bit 13 enables the input buffer chopper, reset 1.
// - bits 12:11 set gain 0.5, 1 or 2; code 3 reserved.
// - bit 10 selects single-ended or differential input.
// - bits 5:4 select reference source, reset bandgap.
// - bit 3 enables reference buffer chopper, reset 0.
// - bit 2 bypasses the reference switched-capacitor filter.
// - bit 0 selects internal or external sensing diode.
// - reserved bits are stored as zero and read back zero.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module awac_top
  import awac_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output      logic              S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output      logic              S_AXI_WREADY,
  // axi4-lite write response
  output      logic [1:0]        S_AXI_BRESP,
  output      logic              S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output      logic              S_AXI_ARREADY,
  // axi4-lite read data
  output      logic [31:0]       S_AXI_RDATA,
  output      logic [1:0]        S_AXI_RRESP,
  output      logic              S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // converter sequencing
  input  wire logic              WARMUP_REQ,
  output      logic              CONVERT_ALLOW,
  // analog front end controls
  output      logic [1:0]        RES_MODE,
  output      logic              BIAS_HALF,
  output      logic              CONV_CHOP_EN,
  output      logic              INBUF_EN,
  output      logic              INBUF_CHOP_EN,
  output      logic [1:0]        INBUF_GAIN,
  output      logic              DIFF_INPUT,
  output      logic [1:0]        VREF_SRC,
  output      logic              VREF_CHOP_EN,
  output      logic              VREF_SCF_BYPASS,
  output      logic              THERMAL_PROBE_ON,
  output      logic              DIODE_EXTERNAL
);
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("address width must be at least 8");
  end

  awac_cfg_if cfg ();

  logic [31:0] settle_ff;
  logic [31:0] analog_ff;
  logic        warm_req_ff;

  // ==========================================================
  // write channel: address and data taken in either order
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              aw_have_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              w_have_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              do_write;

  assign S_AXI_AWREADY = !aw_have_ff && !bvalid_ff;
  assign S_AXI_WREADY  = !w_have_ff && !bvalid_ff;
  assign do_write      = aw_have_ff && w_have_ff && !bvalid_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_ff <= 1'b1;
      aw_addr_ff <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      w_have_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_ff <= 1'b1;
      w_data_ff <= S_AXI_WDATA;
      w_strb_ff <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_have_ff <= 1'b0;
    end
  end

  logic wr_settle;
  logic wr_analog;
  logic wr_status;
  assign wr_settle = do_write && (aw_addr_ff[7:0] == SETTLE_CFG_OFS);
  assign wr_analog = do_write && (aw_addr_ff[7:0] == ANALOG_CFG_OFS);
  assign wr_status = do_write && (aw_addr_ff[7:0] == STATUS_OFS);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_settle || wr_analog || wr_status) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // registers; reserved bits masked to zero on write
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      settle_ff <= {26'h0000000, 1'b0, SETTLE_DUR_RST};
    end else if (wr_settle) begin
      settle_ff <= awac_merge(settle_ff, w_data_ff, w_strb_ff, SETTLE_WMASK);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      analog_ff <= ANALOG_RST;
    end else if (wr_analog) begin
      analog_ff <= awac_merge(analog_ff, w_data_ff, w_strb_ff, ANALOG_WMASK);
    end
  end

  // status bit 1 is a software warm-up request, ored with the pin
  logic sw_req_ff;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sw_req_ff <= 1'b0;
    end else if (wr_status && w_strb_ff[0]) begin
      sw_req_ff <= w_data_ff[1];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      warm_req_ff <= 1'b0;
    end else begin
      warm_req_ff <= WARMUP_REQ || sw_req_ff;
    end
  end

  assign cfg.settle_cfg = settle_ff;
  assign cfg.analog_cfg = analog_ff;
  assign cfg.warm_req   = warm_req_ff;

  awac_settle_timer #(
    .TICK_CYC (TICK_CYCLES)
  ) u_timer (
    .CLOCK (CLOCK),
    .RST   (RST),
    .cfg   (cfg)
  );

  // ==========================================================
  // read channel, one cycle latency
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  ra;
  assign ra            = S_AXI_ARADDR[7:0];
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      if (ra == SETTLE_CFG_OFS) begin
        rdata_ff <= settle_ff;
      end else if (ra == ANALOG_CFG_OFS) begin
        rdata_ff <= analog_ff;
      end else if (ra == STATUS_OFS) begin
        rdata_ff <= {30'h00000000, sw_req_ff, cfg.warm_done};
      end else begin
        rdata_ff <= 32'h00000000;
        rresp_ff <= RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // conversion permission from warm-up done, registered
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CONVERT_ALLOW <= 1'b0;
    end else begin
      CONVERT_ALLOW <= cfg.warm_done;
    end
  end

  // ==========================================================
  // converter core controls
  // each control keeps its own flop; a resolution change touches both RES_MODE and CONV_CHOP_EN
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RES_MODE <= ANALOG_RST[RES_LSB +: 2];
    end else begin
      RES_MODE <= analog_ff[RES_LSB +: 2];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      BIAS_HALF <= 1'b0;
    end else begin
      BIAS_HALF <= analog_ff[BIAS_BIT];
    end
  end

  // chopper is meaningless outside 12-bit mode, so it is forced off there
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CONV_CHOP_EN <= 1'b0;
    end else begin
      CONV_CHOP_EN <= analog_ff[CHOP_BIT] && (analog_ff[RES_LSB +: 2] == RES_12BIT);
    end
  end

  // ==========================================================
  // input buffer controls
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      INBUF_EN <= 1'b0;
    end else begin
      INBUF_EN <= analog_ff[INBUF_EN_BIT];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      INBUF_CHOP_EN <= 1'b0;
    end else begin
      INBUF_CHOP_EN <= analog_ff[INBUF_CHOP_BIT];
    end
  end

  // reserved gain code falls back to unity rather than an undefined setting
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      INBUF_GAIN <= 2'h0;
    end else if (analog_ff[GAIN_LSB +: 2] == GAIN_RESERVED) begin
      INBUF_GAIN <= ANALOG_RST[GAIN_LSB +: 2];
    end else begin
      INBUF_GAIN <= analog_ff[GAIN_LSB +: 2];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DIFF_INPUT <= 1'b0;
    end else begin
      DIFF_INPUT <= analog_ff[DIFF_BIT];
    end
  end

  // ==========================================================
  // reference controls
  // codes 2 and 3 borrow an analog input pin; all four codes are legal
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      VREF_SRC <= 2'h0;
    end else begin
      VREF_SRC <= analog_ff[VREF_LSB +: 2];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      VREF_CHOP_EN <= 1'b0;
    end else begin
      VREF_CHOP_EN <= analog_ff[VREF_CHOP_BIT];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      VREF_SCF_BYPASS <= 1'b0;
    end else begin
      VREF_SCF_BYPASS <= analog_ff[SCF_BYP_BIT];
    end
  end

  // ==========================================================
  // thermal probe controls
  // probe bit passes as written; keeping it to sensor channels is up to software
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      THERMAL_PROBE_ON <= 1'b0;
    end else begin
      THERMAL_PROBE_ON <= analog_ff[PROBE_ON_BIT];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DIODE_EXTERNAL <= 1'b0;
    end else begin
      DIODE_EXTERNAL <= analog_ff[DIODE_EXT_BIT];
    end
  end
endmodule // awac_top

// *** testbench/awac_core_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// converter core: asks for warm-up, counts the wait
module awac_core_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // bench command and block answer
  input  wire logic        run,
  input  wire logic        allow,
  // to block and bench
  output      logic        req,
  output      logic [15:0] wait_cyc
);
  logic        req_ff;
  logic [15:0] wait_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) req_ff <= 1'b0;
    else req_ff <= run;
  end
  // no conversion starts while waiting; a dropped request restarts the count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) wait_ff <= 16'h0;
    else if (!run) wait_ff <= 16'h0;
    else if (req_ff && !allow) wait_ff <= wait_ff + 16'h1;
  end
  assign req      = req_ff;
  assign wait_cyc = wait_ff;
endmodule // awac_core_model

// *** testbench/awac_monitor.sv ***
`timescale 1ns/1ps
// ==========================================================
// port-level checks
module awac_monitor
  import awac_pkg::*;
(
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // bus handshakes
  input wire logic        S_AXI_AWREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // converter side
  input wire logic        WARMUP_REQ,
  input wire logic        CONVERT_ALLOW,
  input wire logic [1:0]  RES_MODE,
  input wire logic        CONV_CHOP_EN,
  input wire logic [1:0]  INBUF_GAIN,
  input wire logic        DIFF_INPUT
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  a_chop_12bit_only: assert property (CONV_CHOP_EN |-> RES_MODE == RES_12BIT)
    else $error("chopper on outside 12-bit mode");
  a_gain_not_reserved: assert property (INBUF_GAIN != GAIN_RESERVED)
    else $error("reserved gain code driven");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write address taken during response");
  a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken during response");
  a_allow_needs_req: assert property (!WARMUP_REQ [*6] |-> !CONVERT_ALLOW)
    else $error("conversions allowed without request");
  a_allow_after_req: assert property ($rose(CONVERT_ALLOW) |-> $past(WARMUP_REQ, 2))
    else $error("conversions allowed too soon");
  a_fe_after_write: assert property ($changed(DIFF_INPUT) |-> $past(S_AXI_BVALID))
    else $error("input mode changed without a write");
endmodule // awac_monitor

bind awac_top awac_monitor u_mon (
  .CLOCK(CLOCK), .RST(RST), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .WARMUP_REQ(WARMUP_REQ), .CONVERT_ALLOW(CONVERT_ALLOW), .RES_MODE(RES_MODE),
  .CONV_CHOP_EN(CONV_CHOP_EN), .INBUF_GAIN(INBUF_GAIN), .DIFF_INPUT(DIFF_INPUT)
);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import awac_pkg::*;
;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        run = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, allow, req;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d, v;
  logic [15:0] wait_cyc;
  wire logic [14:0] fe;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          e;
  initial forever #5 CLOCK = ~CLOCK;
  awac_top u_dut (.CLOCK(CLOCK), .RST(RST), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WARMUP_REQ(req), .CONVERT_ALLOW(allow), .RES_MODE(fe[14:13]), .BIAS_HALF(fe[12]),
    .CONV_CHOP_EN(fe[11]), .INBUF_EN(fe[10]), .INBUF_CHOP_EN(fe[9]), .INBUF_GAIN(fe[8:7]),
    .DIFF_INPUT(fe[6]), .VREF_SRC(fe[5:4]), .VREF_CHOP_EN(fe[3]), .VREF_SCF_BYPASS(fe[2]),
    .THERMAL_PROBE_ON(fe[1]), .DIODE_EXTERNAL(fe[0]));
  awac_core_model u_core (.clock(CLOCK), .rst(RST), .run(run), .allow(allow), .req(req),
    .wait_cyc(wait_cyc));
  // ==========================================================
  // helpers
  task automatic conclude();
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [14:0] exp_fe(input logic [31:0] x);
    logic [1:0] g;
    g = (x[12:11] == GAIN_RESERVED) ? 2'h1 : x[12:11];
    return {x[18:17], x[16], x[15] && (x[18:17] == RES_12BIT), x[14:13], g, x[10], x[5:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
    logic dn;
    dn = 1'b0;
    @(posedge CLOCK);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn) begin
      @(posedge CLOCK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      dn = bvalid;
      rs = bresp;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
    logic dn;
    dn = 1'b0;
    @(posedge CLOCK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge CLOCK);
      if (arvalid && arready) arvalid <= 1'b0;
      dn = rvalid;
      x = rdata;
      rs = rresp;
    end
    rready <= 1'b0;
  endtask
  // hang guard: whole run is well under this many cycles
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(92127));
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk("fe_reset", fe, exp_fe(ANALOG_RST));
    rd(SETTLE_CFG_OFS, d, r);
    chk("settle_reset", d, 32'h0000000f);
    rd(ANALOG_CFG_OFS, d, r);
    chk("analog_reset", d, ANALOG_RST);
    rd(8'h20, d, r);
    chk("rd_unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
    // low loops force every resolution, gain and reference code; probe bit left random,
    // whatever the channel source
    for (int i = 0; i < 14; i++) begin
      v = $urandom & ANALOG_WMASK;
      if (i < 4) v = {v[31:19], i[1:0], v[16:13], i[1:0], v[10:6], i[1:0], v[3:0]};
      wr(ANALOG_CFG_OFS, v, r);
      chk("wr_resp", r, RESP_OKAY);
      rd(ANALOG_CFG_OFS, d, r);
      chk("analog_rb", d, v & ANALOG_WMASK);
      chk("fe_out", fe, exp_fe(v));
    end
    wr(8'h20, 32'h0, r);
    chk("wr_unmapped", r, RESP_SLVERR);
    rd(ANALOG_CFG_OFS, d, r);
    chk("analog_kept", d, v & ANALOG_WMASK);
    wr(SETTLE_CFG_OFS, SETTLE_WMASK, r);
    rd(SETTLE_CFG_OFS, d, r);
    chk("settle_rb", d, SETTLE_WMASK);
    // every setting without the skip bit gives at least 1 us of warm-up
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'h20 | ($urandom & 32'h1f) : (k == 1) ? 32'h0 : (k == 2) ? 32'h1f
        : $urandom & 32'h1f;
      wr(SETTLE_CFG_OFS, v, r);
      if (k == 1) begin
        run <= 1'b1;
        repeat (50) @(posedge CLOCK);
        run <= 1'b0;
        repeat (8) @(posedge CLOCK);
      end
      e = v[5] ? 3 : (v[4:0] + 1) * TICK_CYCLES + 3;
      run <= 1'b1;
      @(posedge CLOCK);
      while (!allow) @(posedge CLOCK);
      chk("warmup_len", (wait_cyc + 4 >= e) && (wait_cyc <= e + 4), 32'h1);
      run <= 1'b0;
      while (allow) @(posedge CLOCK);
    end
    // software request and done flag, set while the pin request also stands
    wr(SETTLE_CFG_OFS, 32'h00000020, r);
    run <= 1'b1;
    wr(STATUS_OFS, 32'h00000002, r);
    rd(STATUS_OFS, d, r);
    chk("status_resp", r, RESP_OKAY);
    chk("status_rb", d, 32'h00000003);
    chk("allow_on", allow, 32'h1);
    wr(STATUS_OFS, 32'h00000000, r);
    rd(STATUS_OFS, d, r);
    chk("status_clr", d, 32'h00000001);
    run <= 1'b0;
    conclude();
  end
endmodule // tb_top
